// [design/gst_defines.svh]
`ifndef GST_DEFINES_SVH
`define GST_DEFINES_SVH

`define GST_COUNT_W 16
`define GST_COUNT_RESET 16'h0000
`define GST_COUNT_MAX 16'hFFFF
`define GST_FOSC_DIV 2'h3
`define GST_SRC_INTERNAL 1'b0
`define GST_SRC_EXTERNAL 1'b1

`endif

// [design/gst_pkg.sv]
package gst_pkg;

  typedef struct packed {
    logic enable;
    logic clock_source_select;
    logic sync_n;
    logic gate_enable;
    logic gate_invert;
    logic gate_select_comparator;
  } gst_ctrl_t;

  typedef struct packed {
    logic write_high;
    logic write_low;
    logic [7:0] data;
    logic clear_flag;
  } gst_sw_t;

  typedef enum logic [1:0] {
    GST_RUN = 2'b00,
    GST_SLEEP = 2'b01
  } gst_mode_t;

  typedef struct packed {
    logic [15:0] count;
    logic [1:0] div;
    logic ext_d1;
    logic ext_d2;
    logic ext_prev;
    logic overflow_flag;
    logic wake;
    logic display_clock;
    gst_mode_t mode;
  } gst_state_t;

endpackage : gst_pkg

// [design/gst_timer.sv]
`timescale 1ns/1ps
`include "gst_defines.svh"

// Functional notes
// - Sixteen-bit up-only counter, read and written as high and low bytes.
// - A byte write replaces that counter byte at once, no staging register.
// - Source select 0 counts the instruction clock, 1 counts the external pin.
// - Internal source is a timer; external source times or counts pin pulses.
// - Counting may be gated by the comparator or the gate pin, software chosen.
// - Overflow wakes the core only with external clock in asynchronous mode.
// - The count clock is offered to the display driver.
module gst_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire gst_pkg::gst_ctrl_t ctrl_i,
  input wire gst_pkg::gst_sw_t sw_i,
  input wire logic sleep_i,
  input wire logic external_count_clock_pin_i,
  input wire logic count_gate_pin_n_i,
  input wire logic comparator_out_i,
  output logic [7:0] count_high_byte_o,
  output logic [7:0] count_low_byte_o,
  output logic overflow_flag_o,
  output logic wake_o,
  output logic display_clock_o
);
  import gst_pkg::*;

  gst_state_t s;
  gst_state_t next_s;
  logic tick;
  logic gate_ok;
  logic ext_rise;
  logic ovf;

  // True when the count clock comes from the external pin rather than the instruction clock.
  function automatic logic src_is_external(input gst_ctrl_t ctrl);
    return ctrl.clock_source_select == `GST_SRC_EXTERNAL;
  endfunction : src_is_external

  always_comb begin
    next_s = s;
    // The external pin passes two flops; edge detection compares the second with a third flop, ext_prev.
    next_s.ext_d1 = external_count_clock_pin_i;
    next_s.ext_d2 = s.ext_d1;
    next_s.ext_prev = s.ext_d2;
    ext_rise = s.ext_d2 && !s.ext_prev;
    next_s.div = s.div + 2'h1;
    // In sleep the instruction clock stops, so only the external source counts.
    if (src_is_external(ctrl_i)) begin
      tick = ext_rise;
    end else begin
      tick = (s.div == `GST_FOSC_DIV) && (s.mode == GST_RUN);
    end
    if (ctrl_i.clock_source_select == `GST_SRC_INTERNAL && ctrl_i.sync_n == 1'b0 && s.mode == GST_SLEEP) begin
      tick = 1'b0;
    end
    // Active-low gate pin; invert lets either level enable counting.
    gate_ok = ctrl_i.gate_select_comparator ? comparator_out_i : !count_gate_pin_n_i;
    gate_ok = gate_ok ^ ctrl_i.gate_invert;
    if (!ctrl_i.gate_enable) begin
      gate_ok = 1'b1;
    end
    // Enable and gate are plain levels, so a count can be held off for any length of time.
    tick = tick && ctrl_i.enable && gate_ok;
    if (src_is_external(ctrl_i) && !ctrl_i.sync_n && s.mode == GST_SLEEP) begin
      tick = ext_rise && ctrl_i.enable && gate_ok;
    end
    ovf = tick && (s.count == `GST_COUNT_MAX);
    next_s.display_clock = tick;
    if (tick) begin
      next_s.count = s.count + 16'h0001;
    end
    // A software byte write wins over a coincident increment in the written byte only; the other byte keeps the increment.
    if (sw_i.write_high) begin
      next_s.count[15:8] = sw_i.data;
    end
    if (sw_i.write_low) begin
      next_s.count[7:0] = sw_i.data;
    end
    // Set wins over clear so an overflow is never lost.
    if (sw_i.clear_flag) begin
      next_s.overflow_flag = 1'b0;
    end
    if (ovf) begin
      next_s.overflow_flag = 1'b1;
    end
    next_s.wake = ovf && s.mode == GST_SLEEP && ctrl_i.sync_n
      && ctrl_i.clock_source_select == `GST_SRC_EXTERNAL;
    case (s.mode)
      GST_RUN: begin
        if (sleep_i) begin
          next_s.mode = GST_SLEEP;
        end
      end
      GST_SLEEP: begin
        if (!sleep_i || next_s.wake) begin
          next_s.mode = GST_RUN;
        end
      end
      default: begin
        next_s.mode = GST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count_high_byte_o = s.count[15:8];
  assign count_low_byte_o = s.count[7:0];
  assign overflow_flag_o = s.overflow_flag;
  assign wake_o = s.wake;
  assign display_clock_o = s.display_clock;

  ovf_sets_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf |=> overflow_flag_o && (s.count == `GST_COUNT_RESET || $past(sw_i.write_high) || $past(sw_i.write_low)))
    else $error("overflow did not wrap and set flag");
  flag_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow_flag_o && !sw_i.clear_flag |=> overflow_flag_o)
    else $error("overflow flag dropped without clear");
  low_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_i.write_low |=> count_low_byte_o == $past(sw_i.data))
    else $error("low byte write not applied");
  high_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_i.write_high |=> count_high_byte_o == $past(sw_i.data))
    else $error("high byte write not applied");
  count_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && !sw_i.write_high && !sw_i.write_low |=> s.count == $past(s.count) + 16'h0001)
    else $error("counter did not increment");
  count_still_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !tick && !sw_i.write_high && !sw_i.write_low |=> $stable(s.count))
    else $error("counter moved without tick");
  gate_blocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.gate_enable && !gate_ok |-> !tick)
    else $error("counted while gated off");
  wake_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_o |-> $past(ctrl_i.clock_source_select) && $past(ctrl_i.sync_n))
    else $error("wake outside external asynchronous mode");
  disp_clock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick |=> display_clock_o)
    else $error("display clock missed a count");

  // Source selection and the instruction-clock divider.
  sleep_stops_int_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !src_is_external(ctrl_i) && s.mode == GST_SLEEP |-> !tick)
    else $error("internal source counted in sleep");

  int_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !src_is_external(ctrl_i) && tick |-> s.div == `GST_FOSC_DIV)
    else $error("internal tick off the divider phase");

  ext_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    src_is_external(ctrl_i) && tick |-> ext_rise)
    else $error("external count without a pin edge");

  ext_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    src_is_external(ctrl_i) && ext_rise && ctrl_i.enable && !ctrl_i.gate_enable |-> tick)
    else $error("external pin edge not counted");

  // Enable and gate must block counting whatever the source.
  enable_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_i.enable |-> !tick)
    else $error("counted while disabled");

  pin_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.gate_enable && !ctrl_i.gate_select_comparator && !ctrl_i.gate_invert && count_gate_pin_n_i |-> !tick)
    else $error("counted while gate pin closed");

  cmp_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.gate_enable && ctrl_i.gate_select_comparator && !ctrl_i.gate_invert && !comparator_out_i |-> !tick)
    else $error("counted while comparator gate closed");

  // Flag, wake and sleep handling.
  flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_i.clear_flag && !ovf |=> !overflow_flag_o)
    else $error("overflow flag not cleared");

  wake_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_o |-> overflow_flag_o)
    else $error("wake without overflow flag");

  wake_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf && s.mode == GST_SLEEP && ctrl_i.sync_n && src_is_external(ctrl_i) |=> wake_o)
    else $error("overflow in sleep did not wake");

  no_wake_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.mode == GST_RUN |=> !wake_o)
    else $error("wake raised while running");

  sleep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.mode == GST_RUN && sleep_i |=> s.mode == GST_SLEEP)
    else $error("sleep request not taken");

  // Display clock and byte independence.
  disp_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !tick |=> !display_clock_o)
    else $error("display clock without a count");

  keep_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_i.write_low && !sw_i.write_high && !tick |=> count_high_byte_o == $past(count_high_byte_o))
    else $error("low byte write disturbed high byte");

  keep_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_i.write_high && !sw_i.write_low && !tick |=> count_low_byte_o == $past(count_low_byte_o))
    else $error("high byte write disturbed low byte");

endmodule : gst_timer

// [testbench/gst_ext_src.sv]
`timescale 1ns/1ps
module gst_ext_src (
  input wire logic clk_i,
  input wire logic run_i,
  output logic pin_o
);
  // The pin clock stands low outside a burst; its slow period suits the two-stage synchroniser.
  always begin
    pin_o = 1'b0;
    @(posedge clk_i);
    while (run_i) begin
      #450;
      // A toggle after the burst ends would be lost in the same-step return to low.
      if (run_i) pin_o = ~pin_o;
    end
  end
endmodule : gst_ext_src

// [testbench/gated_sixteen_bit_timer_tb_top.sv]
`timescale 1ns/1ps
module gated_sixteen_bit_timer_tb_top;
  import gst_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  gst_ctrl_t ctrl_i = '0;
  gst_sw_t sw_i = '0;
  logic run = 1'b0;
  logic pin;
  logic gate_n = 1'b1;
  logic sleep = 1'b0;
  logic wake;
  logic dclk;
  int dc = 0;
  int wk = 0;
  logic [7:0] hi;
  logic [7:0] lo;
  logic flag;
  logic [16:0] expq[$];
  logic [16:0] ev;
  logic [15:0] r;
  event chk;
  int fail_count = 0;
  int num_checks = 0;
  int seed = 78;
  int n = 0;
  always #50 clk_i = ~clk_i;
  always @(posedge pin) n++;
  always @(negedge clk_i) begin
    if (dclk === 1'b1) dc++;
    if (wake === 1'b1) wk++;
  end
  gst_timer i_gst_timer (.clk_i(clk_i), .rst_i(rst_i), .ctrl_i(ctrl_i), .sw_i(sw_i), .sleep_i(sleep),
    .external_count_clock_pin_i(pin), .count_gate_pin_n_i(gate_n), .comparator_out_i(1'b0),
    .count_high_byte_o(hi), .count_low_byte_o(lo), .overflow_flag_o(flag), .wake_o(wake), .display_clock_o(dclk));
  gst_ext_src i_gst_ext_src (.clk_i(clk_i), .run_i(run), .pin_o(pin));
  task automatic report_and_stop;
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #10;
  endtask : cyc
  task automatic expect_v(input logic [16:0] v);
    expq.push_back(v);
    -> chk;
  endtask : expect_v
  task automatic burst(input logic g);
    gate_n = g;
    n = 0;
    dc = 0;
    run = 1'b1;
    cyc(40);
    run = 1'b0;
    cyc(15);
    expect_v({1'b0, g ? 16'h0000 : n[15:0]});
    num_checks++;
    if (dc !== (g ? 0 : n)) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, dc, n);
    end
  endtask : burst
  always @(chk) begin
    ev = expq.pop_front();
    num_checks++;
    if ({flag, hi, lo} !== ev) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, {flag, hi, lo}, ev);
    end
  end
  initial begin
    cyc(5);
    rst_i = 1'b0;
    expect_v(17'h00000);
    r = 16'($random(seed));
    sw_i = '{write_high: 1'b0, write_low: 1'b1, data: r[7:0], clear_flag: 1'b0};
    cyc(1);
    sw_i = '{write_high: 1'b1, write_low: 1'b0, data: r[15:8], clear_flag: 1'b0};
    cyc(1);
    sw_i = '0;
    cyc(1);
    expect_v({1'b0, r});
    sw_i = '{write_high: 1'b1, write_low: 1'b1, data: 8'hFF, clear_flag: 1'b0};
    cyc(1);
    sw_i = '0;
    ctrl_i.enable = 1'b1;
    for (int i = 0; i < 20 && flag !== 1'b1; i++) cyc(1);
    ctrl_i.enable = 1'b0;
    if (flag !== 1'b1) fail_count++;
    expect_v(17'h10000);
    sw_i.clear_flag = 1'b1;
    cyc(1);
    sw_i = '0;
    cyc(1);
    expect_v(17'h00000);
    ctrl_i = '{enable: 1'b1, clock_source_select: 1'b1, sync_n: 1'b0, gate_enable: 1'b1,
      gate_invert: 1'b0, gate_select_comparator: 1'b0};
    burst(1'b1);
    burst(1'b0);
    sleep = 1'b1;
    ctrl_i.sync_n = 1'b1;
    ctrl_i.gate_enable = 1'b0;
    sw_i = '{write_high: 1'b1, write_low: 1'b1, data: 8'hFF, clear_flag: 1'b0};
    cyc(1);
    sw_i = '0;
    run = 1'b1;
    cyc(12);
    run = 1'b0;
    cyc(8);
    num_checks++;
    if (wk !== 1) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, wk, 1);
    end
    report_and_stop();
  end
endmodule : gated_sixteen_bit_timer_tb_top
